// file: verilog/tba_pkg.sv
// package with shared constants for the three-wire bus arbitration ends
package tba_pkg;
  // ==========================================
  // synchroniser and timing
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // ==========================================
  // requester side
  localparam int unsigned HOLD_CYCLES_DEF = 4;
  localparam logic [15:0] HOLD_CYCLES_MAX = 16'hffff;
  // ==========================================
  // reset values of active-low lines (negated)
  localparam logic LINE_NEGATED = 1'b1;
endpackage : tba_pkg

// file: verilog/tba_if.sv
// interface joining the arbiting device and one outside bus master
`timescale 1ns/1ps
interface tba_if;
  // ==========================================
  // arbitration wires, active low
  logic bus_request_n;
  logic grant_out_n;
  logic grant_acknowledge_n;
  // bus status seen by the outside master
  logic address_strobe_n;
  logic transfer_ack_pair_n;
  logic locked_cycle_n;
  // outside master may abort a locked sequence
  logic fault_terminate_n;

  modport device (
    input bus_request_n,
    input grant_acknowledge_n,
    output grant_out_n,
    output address_strobe_n,
    output locked_cycle_n,
    input transfer_ack_pair_n,
    input fault_terminate_n
  );

  modport master (
    output bus_request_n,
    output grant_acknowledge_n,
    input grant_out_n,
    input address_strobe_n,
    input locked_cycle_n,
    output transfer_ack_pair_n,
    output fault_terminate_n
  );
endinterface : tba_if

// file: verilog/tba_arbiter.sv
// device end: request/grant/acknowledge arbiter with bus float control
// Operation
// - request, grant, then acknowledge takes mastership
// - requests accepted at any time
// - grant on recognized request, after started cycle
// - no grant while locked cycle active
// - master holds acknowledge through its cycles
// - master waits strobe, acks, acknowledge negated
// - master may watch only address strobe
// - shared wire-ORed request line allowed
// - pending request regranted, no cycle between
// - arbitration works in halt and fault; i_resetn holds the arbiter idle with grant negated
// - withdrawn request without acknowledge keeps bus
// - mastership ends at acknowledge negation
// - master drops request after acknowledging
// - request and acknowledge synchronised, two flops
// - float after strobe and lock negated
// - state on rising edge, grant pin falling
// - drive resumes on the same edge state returns
// - idle state zero, request goes state one
// - state one to two, two to three
// - three to four, four back to zero
// - request ignored during locked sequence
// - any external scheme following protocol allowed
`timescale 1ns/1ps
module tba_arbiter
  import tba_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  tba_if.device bus,
  input wire logic i_cycle_pending,
  input wire logic i_cycle_start,
  input wire logic i_locked,
  input wire logic i_halted,
  output logic o_float,
  output logic o_bus_drive,
  output logic o_granted,
  output logic o_cycle_busy,
  output logic [2:0] o_arb_state
);
  import tba_pkg::*;

  typedef enum logic [2:0] {
    TBA_IDLE,
    TBA_GRANT,
    TBA_WAIT_ACK,
    TBA_DROP,
    TBA_EXT_OWN
  } tba_state_e;

  // the synchroniser indexing needs at least two stages
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ==========================================
  // input synchronisers
  logic [SYNC_STAGES-1:0] req_sync;
  logic [SYNC_STAGES-1:0] ack_sync;
  logic [SYNC_STAGES-1:0] next_req_sync;
  logic [SYNC_STAGES-1:0] next_ack_sync;
  logic req;
  logic ack;

  // shift asserted levels through two flops before any logic reads them
  always_comb begin
    next_req_sync = {req_sync[SYNC_STAGES-2:0], ~bus.bus_request_n};
    next_ack_sync = {ack_sync[SYNC_STAGES-2:0], ~bus.grant_acknowledge_n};
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_sync <= '0;
      ack_sync <= '0;
    end else begin
      req_sync <= next_req_sync;
      ack_sync <= next_ack_sync;
    end
  end

  assign req = req_sync[SYNC_STAGES-1];
  assign ack = ack_sync[SYNC_STAGES-1];

  // ==========================================
  // own bus cycle tracking
  logic cycle_busy;
  logic next_cycle_busy;
  logic locked;
  logic next_locked;
  logic hold_off;

  // a cycle runs from start until the pending request drops; lock follows input
  always_comb begin
    next_cycle_busy = cycle_busy;
    if (i_cycle_start && !o_float) begin
      next_cycle_busy = 1'b1;
    end else if (!i_cycle_pending) begin
      next_cycle_busy = 1'b0;
    end
    next_locked = i_locked && !o_float;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cycle_busy <= 1'b0;
      locked <= 1'b0;
    end else begin
      cycle_busy <= next_cycle_busy;
      locked <= next_locked;
    end
  end

  // decided but not yet started own cycle defers the grant unless halted; lock blocks it
  assign hold_off = (i_cycle_pending && !cycle_busy && !i_halted) || locked;

  // ==========================================
  // arbiter state machine
  tba_state_e state;
  tba_state_e next_state;

  // only i_resetn resets this machine, so arbitration runs in halt and fault too
  always_comb begin
    next_state = state;
    unique case (state)
      TBA_IDLE: begin
        if (req && !hold_off) begin
          next_state = TBA_GRANT;
        end else if (ack) begin
          next_state = TBA_EXT_OWN;
        end
      end
      TBA_GRANT: begin
        next_state = TBA_WAIT_ACK;
      end
      TBA_WAIT_ACK: begin
        if (ack || !req) begin
          next_state = TBA_DROP;
        end
      end
      TBA_DROP: begin
        next_state = TBA_EXT_OWN;
      end
      TBA_EXT_OWN: begin
        if (!ack) begin
          next_state = TBA_IDLE;
        end else if (req) begin
          next_state = TBA_GRANT;
        end
      end
      default: begin
        next_state = TBA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= TBA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // grant pin, updated on the falling edge after the state change
  logic grant_n;
  logic next_grant_n;

  always_comb begin
    next_grant_n = !((state == TBA_GRANT) || (state == TBA_WAIT_ACK)) || locked;
  end

  always_ff @(negedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      grant_n <= LINE_NEGATED;
    end else begin
      grant_n <= next_grant_n;
    end
  end

  assign bus.grant_out_n = grant_n;

  // ==========================================
  // float control: tristate once strobe and lock are negated
  logic float_req;
  logic floated;
  logic next_floated;

  assign float_req = (state != TBA_IDLE);

  // float rises an edge after the grant state, drops on the edge back to idle
  always_comb begin
    next_floated = 1'b0;
    if (float_req && (next_state != TBA_IDLE) && !cycle_busy && !locked) begin
      next_floated = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      floated <= 1'b0;
    end else begin
      floated <= next_floated;
    end
  end

  // ==========================================
  // outputs; strobe and lock pins are driven negated when the bus is given away
  assign o_float = floated;
  assign o_bus_drive = !floated;
  assign o_granted = !grant_n;
  assign o_cycle_busy = cycle_busy;
  assign o_arb_state = state;
  assign bus.address_strobe_n = floated ? LINE_NEGATED : !cycle_busy;
  assign bus.locked_cycle_n = floated ? LINE_NEGATED : !locked;
endmodule : tba_arbiter

// file: verilog/tba_master.sv
// outside master end: requests the bus, acknowledges, holds for a burst
`timescale 1ns/1ps
module tba_master
  import tba_pkg::*;
#(
  parameter logic [15:0] HOLD_CYCLES = 16'(HOLD_CYCLES_DEF),
  parameter bit CHECK_TACK = 1'b1
)
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  tba_if.master bus,
  input wire logic i_want_bus,
  input wire logic i_abort_locked,
  output logic o_owner,
  output logic o_busy
);
  import tba_pkg::*;

  // a zero hold count would wrap the down counter
  if (HOLD_CYCLES == 16'h0000) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one");
  end

  typedef enum logic [1:0] {
    TBM_IDLE,
    TBM_REQ,
    TBM_OWN
  } tba_mst_state_e;

  // ==========================================
  // synchronise the device outputs
  logic [SYNC_STAGES-1:0] g_sync;
  logic [SYNC_STAGES-1:0] as_sync;
  logic [SYNC_STAGES-1:0] lk_sync;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      g_sync <= '0;
      as_sync <= '0;
      lk_sync <= '0;
    end else begin
      g_sync <= {g_sync[SYNC_STAGES-2:0], ~bus.grant_out_n};
      as_sync <= {as_sync[SYNC_STAGES-2:0], ~bus.address_strobe_n};
      lk_sync <= {lk_sync[SYNC_STAGES-1-1:0], ~bus.locked_cycle_n};
    end
  end

  // ==========================================
  // request, wait for a free bus, acknowledge and hold
  tba_mst_state_e state;
  tba_mst_state_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic bus_free;

  // transfer acks are driven only by this end, so they are released when not owning
  assign bus_free = !as_sync[SYNC_STAGES-1] && (!CHECK_TACK || bus.transfer_ack_pair_n);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      TBM_IDLE: begin
        if (i_want_bus) begin
          next_state = TBM_REQ;
        end
      end
      TBM_REQ: begin
        if (!i_want_bus) begin
          next_state = TBM_IDLE;
        end else if (g_sync[SYNC_STAGES-1] && bus_free) begin
          next_state = TBM_OWN;
          next_cnt = HOLD_CYCLES;
        end
      end
      TBM_OWN: begin
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) begin
          next_state = TBM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= TBM_IDLE;
      cnt <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ==========================================
  // pins: request until acknowledged, acknowledge through ownership
  assign bus.bus_request_n = !(state == TBM_REQ);
  assign bus.grant_acknowledge_n = !(state == TBM_OWN);
  assign bus.transfer_ack_pair_n = LINE_NEGATED;
  assign bus.fault_terminate_n = !(i_abort_locked && lk_sync[SYNC_STAGES-1]);
  assign o_owner = (state == TBM_OWN);
  assign o_busy = (state != TBM_IDLE);
endmodule : tba_master

// file: tb/tba_props.sv
// concurrent checks on the arbitration wires between both ends
`timescale 1ns/1ps
module tba_props (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic bus_request_n,
  input wire logic grant_out_n,
  input wire logic grant_acknowledge_n,
  input wire logic address_strobe_n,
  input wire logic transfer_ack_pair_n,
  input wire logic locked_cycle_n,
  input wire logic fault_terminate_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // takeover steps
  sequence s_take;
    $fell(grant_acknowledge_n);
  endsequence
  sequence s_req_held;
    (!bus_request_n && grant_acknowledge_n && locked_cycle_n)[*8];
  endsequence
  a_no_grant_locked: assert property (
    !locked_cycle_n && $past(!locked_cycle_n) |-> grant_out_n)
    else $error("grant seen while locked");
  a_grant_after_req: assert property ($fell(grant_out_n) |-> $past(!bus_request_n, 2))
    else $error("grant without synchronised request");
  a_grant_timely: assert property (s_req_held |-> ##[0:4] !grant_out_n)
    else $error("pending request not granted");
  a_grant_drops: assert property (bus_request_n[*5] |-> grant_out_n)
    else $error("grant held without request");
  a_ack_ends_grant: assert property (s_take |-> ##[1:5] grant_out_n)
    else $error("grant not negated after acknowledge");
  a_bus_floated: assert property (
    !grant_acknowledge_n |-> address_strobe_n && locked_cycle_n)
    else $error("device drives bus under outside master");
  a_master_waits: assert property (
    s_take |-> $past(!grant_out_n && address_strobe_n && transfer_ack_pair_n))
    else $error("acknowledge without grant and idle bus");
  a_req_released: assert property (s_take |-> ##[0:2] bus_request_n)
    else $error("request kept after acknowledge");
  a_ack_held: assert property (s_take |-> !grant_acknowledge_n[*6])
    else $error("acknowledge released too early");
  // shared fault line stays quiet while nothing is locked
  a_abort_locked_only: assert property (locked_cycle_n[*2] |-> fault_terminate_n)
    else $error("abort outside locked sequence");
endmodule : tba_props

// file: tb/tb.sv
// self-checking bench joining the arbiter and the outside master
`timescale 1ns/1ps
module tb;
  import tba_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic pend = 1'b0, start = 1'b0, lock = 1'b0, halt = 1'b0, want = 1'b0, abort = 1'b0;
  logic flt, drv, gnt, busy, owner, mbusy;
  logic [2:0] st;
  int mismatches = 0;
  int checked = 0;
  tba_if bus ();
  tba_arbiter i_tba_arbiter (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .bus(bus),
    .i_cycle_pending(pend), .i_cycle_start(start), .i_locked(lock), .i_halted(halt),
    .o_float(flt), .o_bus_drive(drv), .o_granted(gnt), .o_cycle_busy(busy), .o_arb_state(st));
  tba_master #(.HOLD_CYCLES(16'h0008)) i_tba_master (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .bus(bus), .i_want_bus(want), .i_abort_locked(abort),
    .o_owner(owner), .o_busy(mbusy));
  tba_props i_tba_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .bus_request_n(bus.bus_request_n), .grant_out_n(bus.grant_out_n),
    .grant_acknowledge_n(bus.grant_acknowledge_n), .address_strobe_n(bus.address_strobe_n),
    .transfer_ack_pair_n(bus.transfer_ack_pair_n), .locked_cycle_n(bus.locked_cycle_n),
    .fault_terminate_n(bus.fault_terminate_n));
  // clock at the core rate
  initial forever #(CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
  // ==========================================
  // compare, wait and handover helpers
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [2:0] pick(input int w);
    case (w)
      0: return {2'b00, gnt};
      1: return {2'b00, owner};
      default: return st;
    endcase
  endfunction : pick
  task automatic cycles(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cycles
  task automatic wait_for(input string name, input int w, input logic [2:0] v);
    int n;
    n = 0;
    while (pick(w) !== v && n < 40) begin
      cycles(1);
      n++;
    end
    chk(name, v, pick(w));
  endtask : wait_for
  task automatic handover();
    wait_for("owner", 1, 3'h1);
    @(negedge i_core_clk);
    want = 1'b0;
    wait_for("state external", 2, 3'h4);
    chk("float", 3'h1, {2'b00, flt});
    chk("grant negated", 3'h0, pick(0));
    wait_for("release", 1, 3'h0);
    wait_for("idle", 2, 3'h0);
    chk("drive at idle", 3'h1, {2'b00, drv});
    cycles(1);
    chk("drive back", 3'h1, {2'b00, drv});
  endtask : handover
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ==========================================
  // scenarios
  initial begin
    cycles(2);
    @(negedge i_core_clk);
    i_resetn = 1'b1;
    cycles(1);
    chk("reset state", 3'h0, st);
    chk("reset grant", 3'h0, pick(0));
    chk("reset float", 3'h0, {2'b00, flt});
    // request while halted; an unstarted own cycle must not defer it then
    @(negedge i_core_clk);
    halt = 1'b1;
    pend = 1'b1;
    want = 1'b1;
    wait_for("grant halted", 0, 3'h1);
    handover();
    // request during a lock, aborted, then withdrawn
    @(negedge i_core_clk);
    halt = 1'b0;
    pend = 1'b0;
    lock = 1'b1;
    abort = 1'b1;
    want = 1'b1;
    cycles(12);
    chk("locked grant", 3'h0, pick(0));
    chk("locked state", 3'h0, st);
    chk("abort line", 3'h0, {2'b00, bus.fault_terminate_n});
    chk("master waiting", 3'h1, {2'b00, mbusy});
    @(negedge i_core_clk);
    want = 1'b0;
    abort = 1'b0;
    cycles(4);
    @(negedge i_core_clk);
    lock = 1'b0;
    cycles(8);
    chk("withdrawn grant", 3'h0, pick(0));
    chk("withdrawn state", 3'h0, st);
    chk("master idle", 3'h0, {2'b00, mbusy});
    // pending request granted once the lock ends
    @(negedge i_core_clk);
    lock = 1'b1;
    want = 1'b1;
    cycles(6);
    @(negedge i_core_clk);
    lock = 1'b0;
    wait_for("grant after lock", 0, 3'h1);
    handover();
    // grant deferred until the decided own cycle starts
    @(negedge i_core_clk);
    pend = 1'b1;
    want = 1'b1;
    cycles(4);
    chk("deferred grant", 3'h0, pick(0));
    @(negedge i_core_clk);
    start = 1'b1;
    @(negedge i_core_clk);
    chk("cycle busy", 3'h1, {2'b00, busy});
    start = 1'b0;
    pend = 1'b0;
    wait_for("grant after start", 0, 3'h1);
    handover();
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    #(CLK_PERIOD_NS * 3000);
    mismatches++;
    end_of_test();
  end
endmodule : tb
